// ===== verilog/dai_cfg.svh
// timing counts and field layout for the 4k x 1 dynamic memory controller
`ifndef DAI_CFG_SVH
`define DAI_CFG_SVH

// ********************************************************************
// clock and rounding
// ********************************************************************
`define DAI_CLK_NS 40
// least times round up to whole clock cycles
`define DAI_CYC_UP(t) (((t) + `DAI_CLK_NS - 1) / `DAI_CLK_NS)
`define DAI_MAX(a, b) (((a) > (b)) ? (a) : (b))

// ********************************************************************
// address layout
// ********************************************************************
`define DAI_ADDR_W 12
`define DAI_ROW_W 6
`define DAI_ROWS 64

// ********************************************************************
// pin timing in ns, slowest grade so every grade is met
// ********************************************************************
`define DAI_CE_ON_NS 300
`define DAI_OUT_DELAY_NS 280
`define DAI_CE_OFF_NS 130
`define DAI_CYCLE_NS 470
`define DAI_RMW_CYCLE_NS 590
`define DAI_WE_TO_CE_OFF_NS 175
`define DAI_WE_PULSE_NS 100
`define DAI_ADDR_HOLD_NS 100
`define DAI_REFRESH_INTERVAL_NS 2000000

// ********************************************************************
// derived cycle counts
// ********************************************************************
`define DAI_SYNC_CYC 3
`define DAI_CE_ON_CYC `DAI_CYC_UP(`DAI_CE_ON_NS)
`define DAI_OUT_DELAY_CYC `DAI_CYC_UP(`DAI_OUT_DELAY_NS)
// one cycle for data landing on a clock edge, one for the agreement register
`define DAI_FILT_CYC 2
`define DAI_READ_ON_CYC \
	`DAI_MAX(`DAI_OUT_DELAY_CYC + `DAI_SYNC_CYC + `DAI_FILT_CYC, \
	`DAI_CE_ON_CYC)
`define DAI_CE_OFF_CYC `DAI_CYC_UP(`DAI_CE_OFF_NS)
`define DAI_CYCLE_CYC `DAI_CYC_UP(`DAI_CYCLE_NS)
`define DAI_RMW_CYCLE_CYC `DAI_CYC_UP(`DAI_RMW_CYCLE_NS)
`define DAI_WRITE_PHASE_CYC \
	`DAI_MAX(`DAI_CYC_UP(`DAI_WE_TO_CE_OFF_NS), \
	`DAI_CYC_UP(`DAI_WE_PULSE_NS))
`define DAI_ADDR_HOLD_CYC `DAI_CYC_UP(`DAI_ADDR_HOLD_NS)
// longest time per row rounds down
`define DAI_REF_TICK_CYC \
	((`DAI_REFRESH_INTERVAL_NS / `DAI_ROWS) / `DAI_CLK_NS)

`endif

// ===== verilog/dai_pkg.sv
// types shared by the dynamic memory controller
package dai_pkg;
	typedef enum logic [1:0] {
		DAI_OP_READ = 2'h0,
		DAI_OP_WRITE = 2'h1,
		DAI_OP_RMW = 2'h2,
		DAI_OP_REF = 2'h3
	} dai_op_t;

	typedef enum logic [2:0] {
		DAI_ST_IDLE,
		DAI_ST_SETUP,
		DAI_ST_ON,
		DAI_ST_WRITE,
		DAI_ST_OFF
	} dai_state_t;
endpackage : dai_pkg

// ===== verilog/dai_refresh.sv
// refresh pacing timer and row counter
`timescale 1ns/10ps
`include "dai_cfg.svh"

module dai_refresh #(
	parameter int TICK_CYC = `DAI_REF_TICK_CYC,
	parameter int ROW_W = `DAI_ROW_W
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic ack,
	output logic pend,
	output logic [ROW_W-1:0] row
);
	logic [15:0] timer;
	logic [15:0] next_timer;
	logic next_pend;
	logic [ROW_W-1:0] next_row;
	logic tick;

	// ****************************************************************
	// pacing
	// ****************************************************************
	// one tick per row slot; the tick sets pending and wins over ack
	always_comb begin
		tick = (timer == 16'(TICK_CYC - 1));
		next_timer = tick ? 16'h0000 : timer + 16'h0001;
		next_row = row;
		next_pend = pend;
		if (ack) begin
			next_pend = 1'b0;
			next_row = row + {{(ROW_W-1){1'b0}}, 1'b1};
		end
		if (tick)
			next_pend = 1'b1;
	end

	// pending starts set so the first cycle after reset is a refresh
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			timer <= 16'h0000;
			pend <= 1'b1;
			row <= '0;
		end else begin
			timer <= next_timer;
			pend <= next_pend;
			row <= next_row;
		end
	end
endmodule : dai_refresh

// ===== verilog/dai_ctrl.sv
// controller that sequences the strobes of a 4k x 1 dynamic memory
`timescale 1ns/10ps
`include "dai_cfg.svh"

module dai_ctrl #(
	parameter int REF_TICK_CYC = `DAI_REF_TICK_CYC
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic REQ,
	input wire logic [1:0] REQ_OP,
	input wire logic [`DAI_ADDR_W-1:0] REQ_ADDR,
	input wire logic REQ_WDATA,
	output logic READY,
	output logic RD_VALID,
	output logic RD_DATA,
	output logic MEM_CE,
	output logic MEM_CS_N,
	output logic MEM_WE_N,
	output logic [`DAI_ADDR_W-1:0] MEM_ADDR,
	output logic MEM_DIN,
	input wire logic MEM_DOUT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!NRST);
	localparam logic [7:0] READ_ON = 8'(`DAI_READ_ON_CYC);
	localparam logic [7:0] WRITE_ON = 8'(`DAI_CE_ON_CYC);
	localparam logic [7:0] WRITE_PHASE = 8'(`DAI_WRITE_PHASE_CYC);
	localparam logic [7:0] OFF_MIN = 8'(`DAI_CE_OFF_CYC);
	localparam logic [7:0] CYC_MIN = 8'(`DAI_CYCLE_CYC);
	localparam logic [7:0] RMW_MIN = 8'(`DAI_RMW_CYCLE_CYC);

	dai_pkg::dai_state_t state, next_state;
	dai_pkg::dai_op_t op, next_op;
	logic [7:0] cnt, next_cnt;
	logic [7:0] tot, next_tot;
	logic init_done, next_init_done;
	logic next_ready, next_rd_valid, next_rd_data;
	logic next_ce, next_cs_n, next_we_n, next_din;
	logic [`DAI_ADDR_W-1:0] next_addr;
	logic ref_pend, ref_ack, next_ref_ack;
	logic [`DAI_ROW_W-1:0] ref_row;
	logic dout_s1, dout_s2, dout_s3, dout_filt, next_dout_filt;

	// ****************************************************************
	// refresh pacing
	// ****************************************************************
	dai_refresh #(
		.TICK_CYC(REF_TICK_CYC),
		.ROW_W(`DAI_ROW_W)
	) u_refresh (
		.clk(CLK),
		.nrst(NRST),
		.ack(ref_ack),
		.pend(ref_pend),
		.row(ref_row)
	);

	// ****************************************************************
	// read data input
	// ****************************************************************
	// pin is asynchronous; a change counts once stages two and three agree
	always_comb begin
		next_dout_filt = (dout_s2 == dout_s3) ? dout_s3 : dout_filt;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			dout_s1 <= 1'b0;
			dout_s2 <= 1'b0;
			dout_s3 <= 1'b0;
			dout_filt <= 1'b0;
		end else begin
			dout_s1 <= MEM_DOUT;
			dout_s2 <= dout_s1;
			dout_s3 <= dout_s2;
			dout_filt <= next_dout_filt;
		end
	end

	// ****************************************************************
	// cycle sequencer
	// ****************************************************************
	// address and data held until next setup
	always_comb begin
		next_state = state;
		next_op = op;
		next_cnt = cnt;
		next_tot = (tot == 8'hff) ? tot : tot + 8'h01;
		next_init_done = init_done;
		next_rd_valid = 1'b0;
		next_rd_data = RD_DATA;
		next_ce = MEM_CE;
		next_cs_n = MEM_CS_N;
		next_we_n = MEM_WE_N;
		next_din = MEM_DIN;
		next_addr = MEM_ADDR;
		next_ref_ack = 1'b0;
		unique case (state)
			dai_pkg::DAI_ST_IDLE: begin
				if (REQ && READY) begin
					next_op = (REQ_OP == 2'h3) ? dai_pkg::DAI_OP_READ :
						dai_pkg::dai_op_t'(REQ_OP);
					next_addr = REQ_ADDR;
					next_din = REQ_WDATA;
					next_cs_n = 1'b0;
					next_we_n = (REQ_OP != 2'h1);
					next_state = dai_pkg::DAI_ST_SETUP;
				end else if (ref_pend) begin
					next_op = dai_pkg::DAI_OP_REF;
					next_addr = {{(`DAI_ADDR_W-`DAI_ROW_W){1'b0}}, ref_row};
					next_cs_n = 1'b1;
					next_we_n = 1'b1;
					next_ref_ack = 1'b1;
					next_state = dai_pkg::DAI_ST_SETUP;
				end
			end
			dai_pkg::DAI_ST_SETUP: begin
				next_ce = 1'b1;
				next_cnt = 8'h01;
				next_tot = 8'h01;
				next_state = dai_pkg::DAI_ST_ON;
			end
			dai_pkg::DAI_ST_ON: begin
				next_cnt = cnt + 8'h01;
				if (op == dai_pkg::DAI_OP_WRITE) begin
					if (cnt == WRITE_ON) begin
						next_ce = 1'b0;
						next_cnt = 8'h01;
						next_state = dai_pkg::DAI_ST_OFF;
					end
				end else if (cnt == READ_ON) begin
					if (op != dai_pkg::DAI_OP_REF) begin
						next_rd_valid = 1'b1;
						next_rd_data = dout_filt;
					end
					if (op == dai_pkg::DAI_OP_RMW) begin
						// write strobe only after data read
						next_we_n = 1'b0;
						next_cnt = 8'h01;
						next_state = dai_pkg::DAI_ST_WRITE;
					end else begin
						next_ce = 1'b0;
						next_cnt = 8'h01;
						next_state = dai_pkg::DAI_ST_OFF;
					end
				end
			end
			dai_pkg::DAI_ST_WRITE: begin
				next_cnt = cnt + 8'h01;
				if (cnt == WRITE_PHASE) begin
					next_ce = 1'b0;
					next_cnt = 8'h01;
					next_state = dai_pkg::DAI_ST_OFF;
				end
			end
			dai_pkg::DAI_ST_OFF: begin
				next_we_n = 1'b1;
				next_cs_n = 1'b1;
				next_cnt = (cnt == 8'hff) ? cnt : cnt + 8'h01;
				if (cnt >= OFF_MIN && tot >= ((op == dai_pkg::DAI_OP_RMW) ?
						RMW_MIN : CYC_MIN)) begin
					next_init_done = 1'b1;
					next_state = dai_pkg::DAI_ST_IDLE;
				end
			end
		endcase
		next_ready = (next_state == dai_pkg::DAI_ST_IDLE) && next_init_done &&
			!ref_pend;
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state <= dai_pkg::DAI_ST_IDLE;
			op <= dai_pkg::DAI_OP_READ;
			cnt <= 8'h00;
			tot <= 8'hff;
			init_done <= 1'b0;
			READY <= 1'b0;
			RD_VALID <= 1'b0;
			RD_DATA <= 1'b0;
			MEM_CE <= 1'b0;
			MEM_CS_N <= 1'b1;
			MEM_WE_N <= 1'b1;
			MEM_ADDR <= '0;
			MEM_DIN <= 1'b0;
			ref_ack <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			cnt <= next_cnt;
			tot <= next_tot;
			init_done <= next_init_done;
			READY <= next_ready;
			RD_VALID <= next_rd_valid;
			RD_DATA <= next_rd_data;
			MEM_CE <= next_ce;
			MEM_CS_N <= next_cs_n;
			MEM_WE_N <= next_we_n;
			MEM_ADDR <= next_addr;
			MEM_DIN <= next_din;
			ref_ack <= next_ref_ack;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	logic [7:0] gap;
	logic last_rmw;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			gap <= 8'hff;
			last_rmw <= 1'b0;
		end else begin
			gap <= (MEM_CE && !$past(MEM_CE)) ? 8'h01 :
				((gap == 8'hff) ? gap : gap + 8'h01);
			if (MEM_CE && !$past(MEM_CE))
				last_rmw <= (op == dai_pkg::DAI_OP_RMW);
		end
	end

	property p_ref_desel;
		MEM_CE && op == dai_pkg::DAI_OP_REF |-> MEM_CS_N && MEM_WE_N;
	endproperty
	a_ref_desel: assert property (p_ref_desel)
		else $error("refresh not a deselected read");
	property p_ref_served;
		$rose(ref_pend) |-> ##[0:40] ref_ack;
	endproperty
	a_ref_served: assert property (p_ref_served)
		else $error("refresh request not served in time");
	property p_init_ref;
		$rose(MEM_CE) && !init_done |-> op == dai_pkg::DAI_OP_REF;
	endproperty
	a_init_ref: assert property (p_init_ref)
		else $error("first cycle after reset not a refresh");
	property p_early_data;
		$rose(MEM_CE) && !MEM_WE_N |-> $past(!MEM_WE_N) && $stable(MEM_DIN);
	endproperty
	a_early_data: assert property (p_early_data)
		else $error("early write data not set before strobe");
	property p_rmw_we_high;
		$rose(MEM_CE) && op == dai_pkg::DAI_OP_RMW |-> MEM_WE_N [*8];
	endproperty
	a_rmw_we_high: assert property (p_rmw_we_high)
		else $error("rmw write strobe fell before access");
	property p_addr_hold;
		$rose(MEM_CE) |-> $stable(MEM_ADDR) [*3];
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("address changed inside hold time");
	property p_addr_setup;
		$rose(MEM_CE) |-> $stable(MEM_ADDR) && $stable(MEM_CS_N);
	endproperty
	a_addr_setup: assert property (p_addr_setup)
		else $error("address moved at strobe rise");
	property p_rmw_space;
		$rose(MEM_CE) && last_rmw |-> gap >= RMW_MIN;
	endproperty
	a_rmw_space: assert property (p_rmw_space)
		else $error("rmw cycles too close");
	property p_row_step;
		ref_ack |=> ref_row == $past(ref_row) + 6'h01;
	endproperty
	a_row_step: assert property (p_row_step)
		else $error("refresh row did not advance by one");
	c_read: cover property (RD_VALID && op == dai_pkg::DAI_OP_READ);
	c_write: cover property ($fell(MEM_CE) && op == dai_pkg::DAI_OP_WRITE);
	c_rmw: cover property ($fell(MEM_WE_N) && op == dai_pkg::DAI_OP_RMW);
	c_refresh: cover property (ref_ack ##[1:40] $fell(MEM_CE));
endmodule : dai_ctrl

// ===== verif/dai_mem_model.sv
// behavioural 4k x 1 dynamic memory that flags strobe timing faults
`timescale 1ns/10ps

module dai_mem_model #(
	parameter int CO_NS = 280,
	parameter int REF_NS = 2000000
) (
	input wire logic ce,
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic [11:0] addr,
	input wire logic din,
	output logic dout,
	output logic oe,
	output int viol,
	output int ref_cnt
);
	logic mem [0:4095];
	logic valid;
	logic read_modify_write;
	realtime rise_t;
	realtime fall_t;
	realtime row_t [0:63];

	// start clean so the first sweep of rows has a known origin
	initial begin
		viol = 0;
		ref_cnt = 0;
		valid = 1'b0;
		read_modify_write = 1'b0;
		rise_t = -1.0e6;
		fall_t = -1.0e6;
		for (int i = 0; i < 64; i++) row_t[i] = 0.0;
		for (int i = 0; i < 4096; i++) mem[i] = 1'b0;
	end

	// strobe rise: spacing, deadlines, refresh and early write
	always @(posedge ce) begin
		if ($realtime - rise_t < (read_modify_write ? 590.0 : 470.0)) viol++;
		if ($realtime - fall_t < 130.0) viol++;
		for (int i = 0; i < 64; i++) begin
			if ($realtime - row_t[i] > REF_NS) viol++;
		end
		read_modify_write = 1'b0;
		rise_t = $realtime;
		row_t[addr[5:0]] = $realtime;
		if (cs_n) ref_cnt++;
		if (!we_n && !cs_n) mem[addr] = din;
		fork
			begin
				#(CO_NS);
				if (ce && we_n) valid = 1'b1;
			end
		join_none
	end

	// late write inside the strobe, read must be out first
	always @(negedge we_n) begin
		if (ce) begin
			if (!valid) viol++;
			read_modify_write = 1'b1;
			if (!cs_n) mem[addr] = din;
			fork
				#15 valid = 1'b0;
			join_none
		end
	end

	// output held after strobe off
	// the unknown-to-low step at start-up is not a real strobe fall
	always @(negedge ce) begin
		if (rise_t >= 0.0) begin
			if ($realtime - rise_t < 300.0) viol++;
			fall_t = $realtime;
			fork
				#30 valid = 1'b0;
			join_none
		end
	end

	// address moves inside the strobe or its hold time
	always @(addr) begin
		if (ce || $realtime - fall_t < 100.0) viol++;
	end

	assign oe = valid & ~cs_n;
	assign dout = oe ? mem[addr] : ~mem[addr];
endmodule : dai_mem_model

// ===== verif/tb.sv
// self-checking bench for the dynamic memory controller
`timescale 1ns/10ps
`include "dai_cfg.svh"

module tb;
	typedef struct packed {
		logic [1:0] op;
		logic [11:0] addr;
		logic wd;
		logic rv;
		logic rd;
	} dai_row_t;
	localparam int TICK = 40;
	// op, address, write bit, read expected, read bit
	localparam logic [16:0] ROWS [13] = '{
		{2'h1, 12'h001, 3'b100}, {2'h1, 12'hfff, 3'b100},
		{2'h1, 12'h040, 3'b000}, {2'h1, 12'h03f, 3'b100},
		{2'h0, 12'h001, 3'b011}, {2'h0, 12'hfff, 3'b011},
		{2'h0, 12'h040, 3'b010}, {2'h0, 12'h03f, 3'b011},
		{2'h2, 12'h001, 3'b011}, {2'h2, 12'h001, 3'b110},
		{2'h0, 12'h001, 3'b011}, {2'h3, 12'h03f, 3'b011},
		{2'h0, 12'hfff, 3'b011}};
	logic CLK, NRST, REQ, REQ_WDATA, READY, RD_VALID, RD_DATA;
	logic MEM_CE, MEM_CS_N, MEM_WE_N, MEM_DIN, MEM_DOUT;
	logic [1:0] REQ_OP;
	logic [11:0] REQ_ADDR, MEM_ADDR;
	logic [5:0] exp_row;
	logic first_ce;
	int miscompares, check_count, viol, ref_cnt, n, r0;

	dai_ctrl #(.REF_TICK_CYC(TICK)) uut (.CLK(CLK), .NRST(NRST),
		.REQ(REQ), .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR),
		.REQ_WDATA(REQ_WDATA), .READY(READY), .RD_VALID(RD_VALID),
		.RD_DATA(RD_DATA), .MEM_CE(MEM_CE), .MEM_CS_N(MEM_CS_N),
		.MEM_WE_N(MEM_WE_N), .MEM_ADDR(MEM_ADDR), .MEM_DIN(MEM_DIN),
		.MEM_DOUT(MEM_DOUT));
	// limit allows two ticks of jitter behind a user access
	dai_mem_model #(.CO_NS(`DAI_OUT_DELAY_NS),
		.REF_NS((TICK * 66) * `DAI_CLK_NS)) mem (.ce(MEM_CE),
		.cs_n(MEM_CS_N), .we_n(MEM_WE_N), .addr(MEM_ADDR), .din(MEM_DIN),
		.dout(MEM_DOUT), .oe(), .viol(viol), .ref_cnt(ref_cnt));

	// clock at 25 MHz
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end

	task chk(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wait_ready;
		n = 0;
		while (READY !== 1'b1 && n < 200) begin
			@(negedge CLK);
			n++;
		end
		chk(READY, 1'b1);
	endtask : wait_ready

	// one user request, pins checked in the setup cycle
	task do_req(input dai_row_t r);
		wait_ready;
		REQ = 1'b1;
		REQ_OP = r.op;
		REQ_ADDR = r.addr;
		REQ_WDATA = r.wd;
		@(negedge CLK);
		REQ = 1'b0;
		chk(MEM_ADDR, r.addr);
		chk({MEM_CE, MEM_CS_N, READY}, 3'b000);
		chk(MEM_WE_N, r.op != 2'h1);
		if (r.op == 2'h1) chk(MEM_DIN, r.wd);
		if (r.rv) begin
			n = 0;
			while (RD_VALID !== 1'b1 && n < 40) begin
				@(negedge CLK);
				n++;
			end
			chk(RD_VALID, 1'b1);
			chk(RD_DATA, r.rd);
		end
	endtask : do_req

	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	// every refresh walks the rows in order, first cycle is one
	always @(posedge MEM_CE) begin
		if (first_ce) chk(MEM_CS_N, 1'b1);
		first_ce = 1'b0;
		if (MEM_CS_N === 1'b1) begin
			chk(MEM_ADDR, {6'h00, exp_row});
			exp_row++;
		end
	end

	always @(negedge NRST) begin
		exp_row = 6'h00;
		first_ce = 1'b1;
	end

	// watchdog sized well above the expected run
	initial begin
		#(20000 * `DAI_CLK_NS);
		miscompares++;
		$display("Error at %0t: run timed out", $time);
		wrap_up;
	end

	initial begin
		{NRST, REQ, REQ_OP, REQ_ADDR, REQ_WDATA} = '0;
		{miscompares, check_count} = '0;
		exp_row = 6'h00;
		first_ce = 1'b1;
		repeat (2) @(negedge CLK);
		NRST = 1'b1;
		for (int i = 0; i < 13; i++) do_req(dai_row_t'(ROWS[i]));
		$display("test table done");
		// request while busy is dropped without a trace
		do_req({2'h1, 12'h0c0, 3'b100});
		@(negedge CLK);
		REQ = 1'b1;
		REQ_ADDR = 12'h040;
		@(negedge CLK);
		REQ = 1'b0;
		do_req({2'h0, 12'h040, 3'b010});
		do_req({2'h0, 12'h0c0, 3'b011});
		$display("test refused done");
		// idle long enough for every row to come round
		r0 = ref_cnt;
		repeat (TICK * 70) @(negedge CLK);
		chk(ref_cnt - r0 > 63, 1'b1);
		chk(viol, 12'h000);
		$display("test refresh done");
		// second reset while idle, then the init refresh
		wait_ready;
		NRST = 1'b0;
		#1;
		chk({READY, RD_VALID, RD_DATA, MEM_CE}, 4'h0);
		chk({MEM_CS_N, MEM_WE_N, MEM_DIN}, 3'b110);
		chk(MEM_ADDR, 12'h000);
		repeat (2) @(negedge CLK);
		NRST = 1'b1;
		wait_ready;
		chk(first_ce, 1'b0);
		chk(viol, 12'h000);
		$display("test reset done");
		wrap_up;
	end
endmodule : tb
